// ===== verilog/e1_rx_sync_slip_status.sv
/*
 * E1 receive multiframe lock status and receive slip buffer full event,
 * with an AHB-Lite register slave and a masked level interrupt.
 * Assumes framer strobes and slip buffer traffic on hclk, one slave on
 * the bus so hready is this block's own hreadyout.
 */
`timescale 1ns/100ps
`include "e1_sync_cfg.svh"
module e1_rx_sync_slip_status
    import e1_sync_pkg::*;
#(
    parameter int FRAME_BYTES = 32,
    parameter int FRAMES = 2,
    parameter int DW = 8,
    parameter int CNT_W = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cas_mfas_strobe,
    input wire logic cas_mfas_ok,
    input wire logic crc_mfas_strobe,
    input wire logic crc_mfas_ok,
    input wire logic rx_wr_valid,
    input wire logic [DW-1:0] rx_wr_data,
    input wire logic rx_rd_req,
    output logic [DW-1:0] rx_rd_data,
    output logic rx_rd_valid,
    output logic irq
);
    localparam int DEPTH = FRAME_BYTES * FRAMES;
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (FRAMES < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("e1_rx_sync_slip_status: bad slip buffer shape");
        end
        if (CNT_W < 4) begin
            $error("e1_rx_sync_slip_status: CNT_W below field width");
        end
        if (DW < 1 || AW + 1 > 32) begin
            $error("e1_rx_sync_slip_status: data or fill width unusable");
        end
    end

    function automatic logic idx_is(input logic [5:0] idx,
                                    input logic [5:0] target);
        idx_is = (idx == target);
    endfunction

    // Bus address phase and registered data phase
    bus_phase_t dp;
    bus_phase_t next_dp;
    wire take = hsel & htrans[1] & hready;
    wire [5:0] a_idx = haddr[`E1S_ADDR_MSB:`E1S_ADDR_LSB];
    wire word_size = (hsize == `E1S_HSIZE_WORD);
    // Partial writes are dropped here rather than merged into fields
    wire dp_write = hwrite & word_size;
    wire rd_take = take & ~hwrite;

    // Address phase hits, one per mapped word
    wire hit_status = idx_is(a_idx, `E1S_IDX_STATUS);
    wire hit_fsel = idx_is(a_idx, `E1S_IDX_FSEL);
    wire hit_fctl = idx_is(a_idx, `E1S_IDX_FCTL);
    wire hit_istat = idx_is(a_idx, `E1S_IDX_ISTAT);
    wire hit_imask = idx_is(a_idx, `E1S_IDX_IMASK);
    wire hit_ctrl = idx_is(a_idx, `E1S_IDX_CTRL);
    wire hit_fill = idx_is(a_idx, `E1S_IDX_FILL);
    // Reading the status word is what clears the full event
    wire rd_status = rd_take & hit_status;
    assign next_dp = '{valid: take, write: dp_write, idx: a_idx};
    wire wr_go = dp.valid & dp.write;
    wire wr_fsel = wr_go & idx_is(dp.idx, `E1S_IDX_FSEL);
    wire wr_fctl = wr_go & idx_is(dp.idx, `E1S_IDX_FCTL);
    wire wr_istat = wr_go & idx_is(dp.idx, `E1S_IDX_ISTAT);
    wire wr_imask = wr_go & idx_is(dp.idx, `E1S_IDX_IMASK);
    wire wr_ctrl = wr_go & idx_is(dp.idx, `E1S_IDX_CTRL);
    // Write data cut to the fields of each register
    wire [2:0] fsel_wdata = hwdata[`E1S_FSEL_CRC_MSB:`E1S_FSEL_CAS_ALG_BIT];
    wire [5:0] fctl_wdata = hwdata[`E1S_FCTL_CRC_MSB:`E1S_FCTL_CAS_LSB];
    wire [1:0] ctrl_wdata = hwdata[`E1S_CTRL_CRC_EN_BIT:`E1S_CTRL_CAS_EN_BIT];
    wire [7:0] imask_wdata = hwdata[7:0] & `E1S_STATUS_BITS;

    // Software registers
    framing_select_t fsel;
    framing_control_t fctl;
    control_t ctrl;
    logic [7:0] imask;
    logic [7:0] istat;
    logic full_event;

    // Lock trackers
    // A disabled function parks its tracker at loss, so its bit reads 0
    logic cas_locked;
    logic crc_locked;
    logic cas_prev;
    logic crc_prev;

    wire [CNT_W-1:0] cas_decl = CNT_W'(fsel.cas_alg ?
        `E1S_CAS_DECL_STRICT : `E1S_CAS_DECL_BASIC);
    wire [CNT_W-1:0] cas_loss = CNT_W'(fctl.cas_loss_error_count);
    // CRC selects are offsets from one, so no code can ask for zero words
    wire [CNT_W-1:0] need_base = CNT_W'(`E1S_NEED_BASE);
    wire [CNT_W-1:0] crc_decl = CNT_W'({2'h0, fsel.crc_decl}) +
        need_base;
    wire [CNT_W-1:0] crc_loss = CNT_W'({2'h0, fctl.crc_loss}) +
        need_base;

    lock_tracker #(
        .CNT_W(CNT_W)
    ) u_cas_lock (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ctrl.cas_enable),
        .strobe(cas_mfas_strobe),
        .ok(cas_mfas_ok),
        .decl_need(cas_decl),
        .loss_need(cas_loss),
        .locked(cas_locked)
    );

    lock_tracker #(
        .CNT_W(CNT_W)
    ) u_crc_lock (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ctrl.crc_enable),
        .strobe(crc_mfas_strobe),
        .ok(crc_mfas_ok),
        .decl_need(crc_decl),
        .loss_need(crc_loss),
        .locked(crc_locked)
    );

    // Receive slip buffer control
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    // Pointers are one bit wider than the address to tell full from empty
    wire [AW:0] frame_span = (AW + 1)'(FRAME_BYTES);
    wire [AW:0] one_step = (AW + 1)'(1);
    wire [AW:0] full_level = (AW + 1)'(DEPTH);
    wire flush = wr_ctrl & hwdata[`E1S_CTRL_FLUSH_BIT];
    wire wr_take = rx_wr_valid & ~flush;
    wire [AW:0] fill = wptr - rptr;
    wire buf_full = (fill == full_level);
    wire buf_empty = (fill == '0);
    wire drop = rx_wr_valid & buf_full & ~flush;
    // A drop cycle skips the read so the read pointer moves only once
    wire rd_ok = rx_rd_req & ~buf_empty & ~drop & ~flush;
    wire [AW:0] rptr_skip = drop ? frame_span : '0;
    wire [AW:0] rptr_step = rd_ok ? one_step : '0;
    wire [AW:0] wptr_step = wr_take ? one_step : '0;
    wire [AW:0] next_rptr = flush ? '0 : rptr + rptr_skip + rptr_step;
    wire [AW:0] next_wptr = flush ? '0 : wptr + wptr_step;

    // A dropped frame costs no copy: the read pointer jumps one frame
    slip_buffer_mem #(
        .DW(DW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_slip_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_take),
        .wr_addr(wptr[AW-1:0]),
        .wr_data(rx_wr_data),
        .rd_en(rd_ok),
        .rd_addr(rptr[AW-1:0]),
        .rd_data(rx_rd_data)
    );

    wire cas_chg = cas_locked ^ cas_prev;
    wire crc_chg = crc_locked ^ crc_prev;

    // Status, interrupt status and mask share one bit layout
    wire [7:0] status_view;
    wire [7:0] events;
    for (genvar b = 0; b < 8; b++) begin : g_bit
        if (b == `E1S_CAS_LOCK_BIT) begin : g_cas
            assign status_view[b] = cas_locked;
            assign events[b] = cas_chg;
        end else if (b == `E1S_CRC_LOCK_BIT) begin : g_crc
            assign status_view[b] = crc_locked;
            assign events[b] = crc_chg;
        end else if (b == `E1S_FULL_BIT) begin : g_full
            assign status_view[b] = full_event;
            assign events[b] = drop;
        end else begin : g_rsvd
            assign status_view[b] = 1'b0;
            assign events[b] = 1'b0;
        end
    end
    wire [7:0] w1c = wr_istat ? hwdata[7:0] : 8'h00;
    wire [7:0] istat_keep = istat & ~w1c;
    // Set wins over a clear written in the same cycle
    wire [7:0] next_istat = (events | istat_keep) & `E1S_STATUS_BITS;
    wire next_full_event = drop | (full_event & ~rd_status);
    // The interrupt follows the interrupt status of the same edge
    wire [7:0] irq_src = next_istat & imask;
    wire next_irq = |irq_src;

    // Read views, zero-extended to the bus width
    wire [31:0] view_status = 32'(status_view);
    wire [31:0] view_fsel = 32'(fsel);
    wire [31:0] view_fctl = 32'(fctl);
    wire [31:0] view_istat = 32'(istat);
    wire [31:0] view_imask = 32'(imask);
    wire [31:0] view_ctrl = 32'(ctrl);
    wire [31:0] view_fill = 32'(fill);
    wire [31:0] read_mux =
        hit_status ? view_status :
        hit_fsel ? view_fsel :
        hit_fctl ? view_fctl :
        hit_istat ? view_istat :
        hit_imask ? view_imask :
        hit_ctrl ? view_ctrl :
        hit_fill ? view_fill : 32'h0000_0000;
    wire [31:0] next_hrdata = rd_take ? read_mux : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            // Zero wait states, always OKAY; partial writes are ignored
            dp <= next_dp;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fsel <= `E1S_FSEL_RST;
            fctl <= `E1S_FCTL_RST;
            ctrl <= `E1S_CTRL_RST;
            imask <= `E1S_MASK_RST;
        end else begin
            if (wr_fsel) begin
                fsel <= fsel_wdata;
            end
            if (wr_fctl) begin
                fctl <= fctl_wdata;
            end
            if (wr_ctrl) begin
                ctrl <= ctrl_wdata;
            end
            if (wr_imask) begin
                imask <= imask_wdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat <= 8'h00;
            full_event <= 1'b0;
            cas_prev <= 1'b0;
            crc_prev <= 1'b0;
            irq <= 1'b0;
        end else begin
            istat <= next_istat;
            full_event <= next_full_event;
            cas_prev <= cas_locked;
            crc_prev <= crc_locked;
            irq <= next_irq;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr <= '0;
            rptr <= '0;
            rx_rd_valid <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            rx_rd_valid <= rd_ok;
        end
    end
endmodule

// ===== verilog/e1_sync_cfg.svh
/*
 * Offsets, field positions, reset values and criteria counts of the E1
 * receive sync and slip status block.
 * Assumes inclusion by bare name from the block's design files only.
 */
`ifndef E1_SYNC_CFG_SVH
`define E1_SYNC_CFG_SVH

// Word indices, byte address is four times the index
`define E1S_IDX_STATUS 6'h00
`define E1S_IDX_FSEL 6'h01
`define E1S_IDX_FCTL 6'h02
`define E1S_IDX_ISTAT 6'h03
`define E1S_IDX_IMASK 6'h04
`define E1S_IDX_CTRL 6'h05
`define E1S_IDX_FILL 6'h06

`define E1S_ADDR_LSB 2
`define E1S_ADDR_MSB 7
`define E1S_HSIZE_WORD 3'h2

// Status bit positions, shared by status, interrupt status and mask
`define E1S_CAS_LOCK_BIT 4
`define E1S_CRC_LOCK_BIT 3
`define E1S_FULL_BIT 2
`define E1S_STATUS_BITS 8'h1c

// Framing select fields
`define E1S_FSEL_CAS_ALG_BIT 0
`define E1S_FSEL_CRC_LSB 1
`define E1S_FSEL_CRC_MSB 2
// Framing control fields
`define E1S_FCTL_CAS_LSB 0
`define E1S_FCTL_CAS_MSB 3
`define E1S_FCTL_CRC_LSB 4
`define E1S_FCTL_CRC_MSB 5
// Control fields
`define E1S_CTRL_CAS_EN_BIT 0
`define E1S_CTRL_CRC_EN_BIT 1
`define E1S_CTRL_FLUSH_BIT 2

// Reset values
`define E1S_FSEL_RST 3'h0
`define E1S_FCTL_RST 6'h13
`define E1S_CTRL_RST 2'h3
`define E1S_MASK_RST 8'h00

// Consecutive good words needed to declare lock, and the base added to both CRC selects
`define E1S_CAS_DECL_BASIC 4'h1
`define E1S_CAS_DECL_STRICT 4'h2
`define E1S_NEED_BASE 4'h1

`endif

// ===== verilog/e1_sync_pkg.sv
/*
 * Types of the E1 receive sync and slip status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package e1_sync_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] idx;
    } bus_phase_t;

    typedef struct packed {
        logic [1:0] crc_decl;
        logic cas_alg;
    } framing_select_t;

    typedef struct packed {
        logic [1:0] crc_loss;
        logic [3:0] cas_loss_error_count;
    } framing_control_t;

    typedef struct packed {
        logic crc_enable;
        logic cas_enable;
    } control_t;

endpackage

// ===== verilog/lock_tracker.sv
/*
 * Alignment lock tracker: counts consecutive good or errored alignment
 * words and declares lock or loss of lock at programmable counts.
 * Assumes strobe and ok come from framer logic on hclk.
 */
`timescale 1ns/100ps
module lock_tracker #(
    parameter int CNT_W = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic strobe,
    input wire logic ok,
    input wire logic [CNT_W-1:0] decl_need,
    input wire logic [CNT_W-1:0] loss_need,
    output logic locked
);
    initial begin
        if (CNT_W < 2) begin
            $error("lock_tracker: CNT_W below 2");
        end
    end

    logic [CNT_W-1:0] run;
    wire [CNT_W:0] run_inc = {1'b0, run} + {{CNT_W{1'b0}}, 1'b1};
    // A need of zero behaves as one
    wire decl_hit = run_inc >= {1'b0, decl_need};
    wire loss_hit = run_inc >= {1'b0, loss_need};
    wire counts = locked ? ~ok : ok;
    wire flip = strobe & counts & (locked ? loss_hit : decl_hit);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            locked <= 1'b0;
            run <= '0;
        end else if (!enable) begin
            // Meaningless while disabled; held at loss of lock
            locked <= 1'b0;
            run <= '0;
        end else if (strobe) begin
            locked <= locked ^ flip;
            run <= (counts && !flip) ? run_inc[CNT_W-1:0] : '0;
        end
    end
endmodule

// ===== verilog/slip_buffer_mem.sv
/*
 * Storage of the receive slip buffer: one write port, one read port,
 * read data from a register.
 * Assumes addresses are in range and come from hclk logic.
 */
`timescale 1ns/100ps
module slip_buffer_mem #(
    parameter int DW = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("slip_buffer_mem: DEPTH exceeds address range");
        end
    end

    logic [DW-1:0] store [DEPTH];

    // No reset on the array keeps it in plain RAM
    always_ff @(posedge hclk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end
endmodule

// ===== dv/e1_rx_sync_slip_status_checker.sv
/* Assertions on the ports of the E1 sync and slip status block.
   Assumes one AHB-Lite slave, so hready is its own hreadyout. */
`timescale 1ns/100ps
module e1_rx_sync_slip_status_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_rd_req,
    input wire logic rx_rd_valid,
    input wire logic irq
);
    logic rd_ph;
    logic wr_ph;
    logic [5:0] ph_idx;
    logic [7:0] mask_sh;
    wire logic take = hsel & htrans[1] & hready;
    // Shadow of the mask, so irq can be tied to what software enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            ph_idx <= 6'h0;
            mask_sh <= 8'h0;
        end else begin
            rd_ph <= take & !hwrite;
            wr_ph <= take & hwrite & (hsize == 3'h2);
            if (take) begin
                ph_idx <= haddr[7:2];
            end
            if (wr_ph && ph_idx == 6'h04) begin
                mask_sh <= hwdata[7:0] & 8'h1c;
            end
        end
    end
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero wait OKAY");
    chk_idle_rdata: assert property (!rd_ph |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_status_bits: assert property (rd_ph && ph_idx == 6'h0 |->
        (hrdata & ~32'h1c) == 32'h0) else $error("stray status bits");
    chk_unmapped_zero: assert property (rd_ph && ph_idx > 6'h6 |->
        hrdata == 32'h0) else $error("unmapped read not zero");
    chk_fill_bound: assert property (rd_ph && ph_idx == 6'h6 |->
        hrdata <= 32'd64) else $error("fill above depth");
    chk_rdvalid_cause: assert property (rx_rd_valid |->
        $past(rx_rd_req)) else $error("byte without request");
    chk_irq_masked: assert property (irq |-> $past(mask_sh) != 8'h0)
        else $error("irq while all masked");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !irq &&
        !rx_rd_valid && hrdata == 32'h0) else $error("outputs after reset");
endmodule
bind e1_rx_sync_slip_status e1_rx_sync_slip_status_checker i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_rd_req(rx_rd_req), .rx_rd_valid(rx_rd_valid),
    .irq(irq)
);

// ===== dv/e1_rx_sync_slip_status_tb.sv
/* Self-checking bench of the E1 sync and slip status block.
   Assumes the checker file is compiled with the design. */
`timescale 1ns/100ps
module e1_rx_sync_slip_status_tb import e1_sync_pkg::*;;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic cas_mfas_strobe = 0, cas_mfas_ok = 0, crc_mfas_strobe = 0;
    logic crc_mfas_ok = 0, rx_wr_valid = 0, rx_rd_req = 0;
    logic [7:0] rx_wr_data = 0, rx_rd_data;
    logic hreadyout, hresp, rx_rd_valid, irq;
    int error_cnt = 0, n_checks = 0;
    always #12.5 hclk = ~hclk;
    e1_rx_sync_slip_status i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .cas_mfas_strobe(cas_mfas_strobe), .cas_mfas_ok(cas_mfas_ok),
        .crc_mfas_strobe(crc_mfas_strobe), .crc_mfas_ok(crc_mfas_ok),
        .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data),
        .rx_rd_req(rx_rd_req), .rx_rd_data(rx_rd_data),
        .rx_rd_valid(rx_rd_valid), .irq(irq)
    );
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Never assumes a latency: only the watchdog ends a wait
    task automatic hwait();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask
    // Slip raises a buffer write in the address phase cycle
    task automatic xfer(input logic w, input logic [31:0] a, wd,
            input logic [2:0] sz, input logic slip);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= sz;
        rx_wr_valid <= slip;
        hwait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        rx_wr_valid <= 1'b0;
        hwdata <= wd;
        hwait();
        d = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, wd);
        xfer(1'b1, a, wd, 3'h2, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, m, e);
        xfer(1'b0, a, 32'h0, 3'h2, 1'b0);
        cmp(d & m, e);
    endtask
    task automatic words(input logic crc, ok, input int n);
        repeat (n) begin
            @(posedge hclk);
            cas_mfas_strobe <= !crc;
            crc_mfas_strobe <= crc;
            cas_mfas_ok <= ok;
            crc_mfas_ok <= ok;
        end
        @(posedge hclk);
        cas_mfas_strobe <= 1'b0;
        crc_mfas_strobe <= 1'b0;
    endtask
    // Leaves the next byte value waiting on the data input
    task automatic push(input int n, input logic [7:0] v);
        repeat (n) begin
            @(posedge hclk);
            rx_wr_valid <= 1'b1;
            rx_wr_data <= v;
            v++;
        end
        @(posedge hclk);
        rx_wr_valid <= 1'b0;
        rx_wr_data <= v;
    endtask
    task automatic pop(input logic [7:0] e, input logic vexp);
        @(posedge hclk);
        rx_rd_req <= 1'b1;
        @(posedge hclk);
        rx_rd_req <= 1'b0;
        #1;
        cmp({31'h0, rx_rd_valid}, {31'h0, vexp});
        if (vexp) begin
            cmp({24'h0, rx_rd_data}, {24'h0, e});
        end
    endtask
    task automatic t_reset();
        logic [31:0] v [8] = '{0, 0, 32'h13, 0, 0, 32'h3, 0, 0};
        for (int i = 0; i < 8; i++) begin
            rd(32'(i * 4), 32'hffffffff, v[i]);
        end
        xfer(1'b1, 32'h4, 32'h7, 3'h0, 1'b0);
        rd(32'h4, 32'hffffffff, 32'h0);
    endtask
    task automatic t_cas();
        words(0, 1, 1);
        rd(32'h0, 32'h10, 32'h10);
        words(0, 0, 2);
        words(0, 1, 1);
        words(0, 0, 2);
        rd(32'h0, 32'h10, 32'h10);
        words(0, 0, 1);
        rd(32'h0, 32'h10, 32'h0);
        wr(32'h4, 32'h1);
        words(0, 1, 1);
        rd(32'h0, 32'h10, 32'h0);
        words(0, 1, 1);
        rd(32'h0, 32'h10, 32'h10);
        wr(32'h0, 32'h0);
        rd(32'h0, 32'h10, 32'h10);
        wr(32'h8, 32'h11);
        words(0, 0, 1);
        rd(32'h0, 32'h10, 32'h0);
    endtask
    task automatic t_crc();
        wr(32'h4, 32'h2);
        words(1, 1, 1);
        rd(32'h0, 32'h8, 32'h0);
        words(1, 1, 1);
        rd(32'h0, 32'h8, 32'h8);
        words(1, 0, 1);
        rd(32'h0, 32'h8, 32'h8);
        words(1, 0, 1);
        rd(32'h0, 32'h8, 32'h0);
        wr(32'h14, 32'h0);
        words(0, 1, 1);
        words(1, 1, 2);
        rd(32'h0, 32'h18, 32'h0);
        wr(32'h14, 32'h3);
    endtask
    task automatic t_slip();
        rd(32'hc, 32'h18, 32'h18);
        wr(32'hc, 32'h1c);
        wr(32'h10, 32'h4);
        push(64, 8'h0);
        rd(32'h0, 32'h4, 32'h0);
        push(1, 8'h40);
        rd(32'h18, 32'hff, 32'd33);
        cmp({31'h0, irq}, 32'h1);
        rd(32'h0, 32'h4, 32'h4);
        rd(32'h0, 32'h4, 32'h0);
        wr(32'hc, 32'h4);
        rd(32'hc, 32'h4, 32'h0);
        cmp({31'h0, irq}, 32'h0);
        pop(8'h20, 1);
        push(32, 8'h41);
        xfer(1'b0, 32'h0, 32'h0, 3'h2, 1'b1);
        cmp(d & 32'h4, 32'h0);
        rd(32'h0, 32'h4, 32'h4);
        cmp({31'h0, irq}, 32'h1);
        wr(32'h10, 32'h0);
        rd(32'hc, 32'h4, 32'h4);
        cmp({31'h0, irq}, 32'h0);
        for (int i = 0; i < 33; i++) begin
            pop(8'(8'h41 + i), 1);
        end
        pop(8'h0, 0);
        push(3, 8'h10);
        rd(32'h18, 32'hff, 32'd3);
        wr(32'h14, 32'h7);
        rd(32'h14, 32'hff, 32'h3);
        rd(32'h18, 32'hff, 32'h0);
        pop(8'h0, 0);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_cas();
        t_crc();
        t_slip();
        give_verdict();
    end
    // The sequence needs about 350 cycles
    initial begin
        #(25 * 20000);
        error_cnt++;
        give_verdict();
    end
endmodule
